// ===== verilog/serial_pkg.sv
`default_nettype none
package serial_pkg;
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 32;
  localparam int IDX_W  = 16;
  localparam int ADR_LSB = 2;
  localparam int REL_W  = 10;
  localparam int DIV_W  = 5;
  localparam int TMR_W  = 17;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] CTRL_IDX [NUM_CH] = '{16'h0098, 16'h00B9};
  localparam logic [IDX_W-1:0] BUF_IDX  [NUM_CH] = '{16'h0099, 16'h00BA};
  localparam logic [IDX_W-1:0] FAST_IDX [NUM_CH] = '{16'h00D8, 16'h00BD};
  localparam logic [IDX_W-1:0] RELL_IDX [NUM_CH] = '{16'h8068, 16'h00BB};
  localparam logic [IDX_W-1:0] RELH_IDX [NUM_CH] = '{16'h8069, 16'h00BC};

  // control register fields
  localparam int MODE_BIT = 7;
  localparam int IE_BIT   = 6;
  localparam int MPE_BIT  = 5;
  localparam int REN_BIT  = 4;
  localparam int TB8_BIT  = 3;
  localparam int RB8_BIT  = 2;
  localparam int TI_BIT   = 1;
  localparam int RI_BIT   = 0;
  localparam int FAST_EN_BIT = 7;

  // reset values
  localparam logic [7:0]       BYTE_RST = 8'h00;
  localparam logic [REL_W-1:0] REL_RST  = 10'h000;
  localparam logic [DIV_W-1:0] DIV_RST  = 5'h00;

  // baud and frame figures
  localparam logic [TMR_W-1:0] SLOW_MULT   = 17'h00020;
  localparam logic [TMR_W-1:0] RELOAD_SPAN = 17'h00400;
  localparam logic [3:0] BITS_NINE  = 4'h9;
  localparam logic [3:0] BITS_EIGHT = 4'h8;

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001, TX_START = 4'b0010, TX_DATA = 4'b0100, TX_STOP = 4'b1000
  } tx_state_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001, RX_START = 4'b0010, RX_DATA = 4'b0100, RX_STOP = 4'b1000
  } rx_state_t;
endpackage
`default_nettype wire

// ===== verilog/dual_async_serial_transceiver.sv
// Behaviour
// - two identical full-duplex channels, each holding one received byte meanwhile
// - frame mode bit: 0 selects nine data bits, 1 selects eight
// - normal bit time is 32 times (1024 minus reload) clocks
// - buffer write sends start 0, data LSB first, ninth bit in nine-bit mode only, stop 1
// - receiver syncs on RX falling edge, stores byte and ninth bit
// - eight-bit mode: received ninth-bit flag takes the stop bit
// - nine-bit multiprocessor filter flags only frames whose ninth bit is 1
// - channel interrupt enable gates done flags onto interrupt request
// - frames are received only while receive enable is 1
// - done flags read 1 when set, cleared only by writing 1
// - buffer read returns the last received byte, not the sent one
// - fast baud: bit time is (divider+1) times (1024 minus reload)
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module dual_async_serial_transceiver
(
  input  wire logic                            clk_i,
  input  wire logic                            rst_i,
  input  wire logic                            cyc_i,
  input  wire logic                            stb_i,
  input  wire logic                            we_i,
  input  wire logic [serial_pkg::ADDR_W-1:0]   adr_i,
  input  wire logic [3:0]                      sel_i,
  input  wire logic [serial_pkg::DATA_W-1:0]   dat_i,
  output var  logic [serial_pkg::DATA_W-1:0]   dat_o,
  output var  logic                            ack_o,
  input  wire logic [serial_pkg::NUM_CH-1:0]   rxd_i,
  output var  logic [serial_pkg::NUM_CH-1:0]   txd_o,
  output var  logic [serial_pkg::NUM_CH-1:0]   irq_o
);
  import serial_pkg::*;

  // register index match on the word address
  function automatic logic idx_hit(input logic [ADDR_W-1:0] adr,
                                   input logic [IDX_W-1:0] idx);
    idx_hit = (adr[ADDR_W-1:ADR_LSB] == idx);
  endfunction

  // bit time in clocks for either baud scheme
  function automatic logic [TMR_W-1:0] bit_period(input logic fast,
                                                  input logic [DIV_W-1:0] div,
                                                  input logic [REL_W-1:0] rel);
    logic [TMR_W-1:0] span;
    span = RELOAD_SPAN - TMR_W'(rel);
    bit_period = fast ? TMR_W'(span * (TMR_W'(div) + 17'h00001))
                      : TMR_W'(span * SLOW_MULT);
  endfunction

  logic                req;
  logic                wr_go;
  logic                stall;
  logic                issue;
  logic [7:0]          rd_byte;
  logic [NUM_CH-1:0]   hit_ctrl;
  logic [NUM_CH-1:0]   hit_buf;
  logic [NUM_CH-1:0]   hit_fast;
  logic [NUM_CH-1:0]   hit_rell;
  logic [NUM_CH-1:0]   hit_relh;
  logic [NUM_CH-1:0]   buf_full;
  logic [7:0]          ctrl_rd [NUM_CH];
  logic [7:0]          fast_rd [NUM_CH];
  logic [7:0]          rell_rd [NUM_CH];
  logic [7:0]          relh_rd [NUM_CH];
  logic [7:0]          rxbuf_rd [NUM_CH];

  // bus strobes; a write lands on the edge that sees ack high
  assign req   = cyc_i & stb_i;
  assign wr_go = req & we_i & ack_o & sel_i[0];
  assign stall = we_i & |(hit_buf & buf_full);
  assign issue = req & ~ack_o & ~stall;

  // read data selection
  always_comb
  begin
    rd_byte = BYTE_RST;
    for (int c = 0; c < NUM_CH; c++)
    begin
      if (hit_ctrl[c]) rd_byte = ctrl_rd[c];
      if (hit_buf[c])  rd_byte = rxbuf_rd[c];
      if (hit_fast[c]) rd_byte = fast_rd[c];
      if (hit_rell[c]) rd_byte = rell_rd[c];
      if (hit_relh[c]) rd_byte = relh_rd[c];
    end
  end

  // one-wait-state slave; unmapped addresses ack with zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end
    else
    begin
      ack_o <= issue;
      if (issue)
        dat_o <= {24'h000000, rd_byte};
    end
  end

  // one identical transceiver per channel
  generate
    for (genvar c = 0; c < NUM_CH; c++)
    begin : g_ch
      logic                frame_mode_select;
      logic                channel_irq_enable;
      logic                multiproc_filter_enable;
      logic                receive_enable_bit;
      logic                tx_ninth_bit;
      logic                rx_ninth_bit;
      logic                tx_done_flag;
      logic                rx_done_flag;
      logic                fast_baud_enable;
      logic [DIV_W-1:0]    fast_baud_divider;
      logic [REL_W-1:0]    baud_reload_value;
      logic [7:0]          rx_byte;
      logic [8:0]          fifo_mem [2];
      logic                fifo_wp;
      logic                fifo_rp;
      logic [1:0]          fifo_cnt;
      tx_state_t           tx_state;
      logic [TMR_W-1:0]    tx_tmr;
      logic [3:0]          tx_cnt;
      logic [8:0]          tx_sh;
      rx_state_t           rx_state;
      logic [TMR_W-1:0]    rx_tmr;
      logic [3:0]          rx_cnt;
      logic [8:0]          rx_sh;
      logic                rx_prev;
      logic                w_ctrl;
      logic                w_buf;
      logic [TMR_W-1:0]    period;
      logic [TMR_W-1:0]    half;
      logic [3:0]          last_bit;
      logic                fifo_valid;
      logic                fifo_pop;
      logic                tx_tick;
      logic                tx_end;
      logic                rx_tick;
      logic                rx_half;
      logic                rx_fall;
      logic                rx_done;
      logic                rx_keep;

      // address decode and write strobes
      assign hit_ctrl[c] = idx_hit(adr_i, CTRL_IDX[c]);
      assign hit_buf[c]  = idx_hit(adr_i, BUF_IDX[c]);
      assign hit_fast[c] = idx_hit(adr_i, FAST_IDX[c]);
      assign hit_rell[c] = idx_hit(adr_i, RELL_IDX[c]);
      assign hit_relh[c] = idx_hit(adr_i, RELH_IDX[c]);
      assign w_ctrl = wr_go & hit_ctrl[c];
      assign w_buf  = wr_go & hit_buf[c];

      // register read images
      assign ctrl_rd[c] = {frame_mode_select, channel_irq_enable, multiproc_filter_enable,
                           receive_enable_bit, tx_ninth_bit, rx_ninth_bit,
                           tx_done_flag, rx_done_flag};
      assign fast_rd[c]  = {fast_baud_enable, 2'b00, fast_baud_divider};
      assign rell_rd[c]  = baud_reload_value[7:0];
      assign relh_rd[c]  = {6'b000000, baud_reload_value[REL_W-1:8]};
      assign rxbuf_rd[c] = rx_byte;

      // bit timing and frame length
      assign period   = bit_period(fast_baud_enable, fast_baud_divider, baud_reload_value);
      assign half     = (period > 17'h00001) ? (period >> 1) : 17'h00001;
      assign last_bit = (frame_mode_select ? BITS_EIGHT : BITS_NINE) - 4'h1;
      assign tx_tick  = (tx_tmr >= period - 17'h00001);
      assign rx_tick  = (rx_tmr >= period - 17'h00001);
      assign rx_half  = (rx_tmr >= half - 17'h00001);

      // two-entry transmit buffer; a full buffer stalls the bus ack
      assign buf_full[c] = fifo_cnt[1];
      assign fifo_valid  = (fifo_cnt != 2'b00);
      assign fifo_pop    = fifo_valid & (tx_state == TX_IDLE);

      // event strobes
      assign tx_end  = (tx_state == TX_STOP) & tx_tick;
      assign rx_fall = rx_prev & ~rxd_i[c];
      assign rx_done = (rx_state == RX_STOP) & rx_tick;
      assign rx_keep = rx_done & (frame_mode_select | ~multiproc_filter_enable
                                  | rx_sh[8]);

      // control register; hardware set wins over a software clear
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          {frame_mode_select, channel_irq_enable, multiproc_filter_enable,
           receive_enable_bit, tx_ninth_bit} <= BYTE_RST[7:3];
          rx_ninth_bit <= 1'b0;
          tx_done_flag <= 1'b0;
          rx_done_flag <= 1'b0;
        end
        else
        begin
          if (w_ctrl)
          begin
            frame_mode_select       <= dat_i[MODE_BIT];
            channel_irq_enable      <= dat_i[IE_BIT];
            multiproc_filter_enable <= dat_i[MPE_BIT];
            receive_enable_bit      <= dat_i[REN_BIT];
            tx_ninth_bit            <= dat_i[TB8_BIT];
          end
          if (rx_keep)
            rx_ninth_bit <= frame_mode_select ? rxd_i[c] : rx_sh[8];
          else if (w_ctrl)
            rx_ninth_bit <= dat_i[RB8_BIT];
          tx_done_flag <= tx_end | (tx_done_flag & ~(w_ctrl & dat_i[TI_BIT]));
          rx_done_flag <= rx_keep | (rx_done_flag & ~(w_ctrl & dat_i[RI_BIT]));
        end
      end

      // baud registers and received byte
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          fast_baud_enable  <= 1'b0;
          fast_baud_divider <= DIV_RST;
          baud_reload_value <= REL_RST;
          rx_byte           <= BYTE_RST;
        end
        else
        begin
          if (wr_go & hit_fast[c])
          begin
            fast_baud_enable  <= dat_i[FAST_EN_BIT];
            fast_baud_divider <= dat_i[DIV_W-1:0];
          end
          if (wr_go & hit_rell[c])
            baud_reload_value[7:0] <= dat_i[7:0];
          if (wr_go & hit_relh[c])
            baud_reload_value[REL_W-1:8] <= dat_i[REL_W-9:0];
          if (rx_keep)
            rx_byte <= rx_sh[7:0];
        end
      end

      // transmit buffer storage, ninth bit captured with the byte
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          fifo_wp  <= 1'b0;
          fifo_rp  <= 1'b0;
          fifo_cnt <= 2'b00;
        end
        else
        begin
          if (w_buf)
          begin
            fifo_mem[fifo_wp] <= {tx_ninth_bit, dat_i[7:0]};
            fifo_wp <= ~fifo_wp;
          end
          if (fifo_pop)
            fifo_rp <= ~fifo_rp;
          fifo_cnt <= fifo_cnt + {1'b0, w_buf} - {1'b0, fifo_pop};
        end
      end

      // transmitter: start, data LSB first, stop
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          tx_state <= TX_IDLE;
          txd_o[c] <= 1'b1;
          tx_tmr   <= '0;
          tx_cnt   <= 4'h0;
          tx_sh    <= 9'h000;
        end
        else
        begin
          tx_tmr <= tx_tick ? '0 : tx_tmr + 17'h00001;
          unique case (tx_state)
            TX_IDLE:
            begin
              tx_tmr <= '0;
              if (fifo_valid)
              begin
                tx_sh    <= fifo_mem[fifo_rp];
                txd_o[c] <= 1'b0;
                tx_state <= TX_START;
              end
            end
            TX_START:
              if (tx_tick)
              begin
                txd_o[c] <= tx_sh[0];
                tx_sh    <= tx_sh >> 1;
                tx_cnt   <= 4'h0;
                tx_state <= TX_DATA;
              end
            TX_DATA:
              if (tx_tick)
              begin
                if (tx_cnt == last_bit)
                begin
                  txd_o[c] <= 1'b1;
                  tx_state <= TX_STOP;
                end
                else
                begin
                  txd_o[c] <= tx_sh[0];
                  tx_sh    <= tx_sh >> 1;
                  tx_cnt   <= tx_cnt + 4'h1;
                end
              end
            TX_STOP:
              if (tx_tick)
                tx_state <= TX_IDLE;
          endcase
        end
      end

      // receiver: mid-bit sampling, aborted when reception is disabled
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          rx_state <= RX_IDLE;
          rx_prev  <= 1'b1;
          rx_tmr   <= '0;
          rx_cnt   <= 4'h0;
          rx_sh    <= 9'h000;
        end
        else
        begin
          rx_prev <= rxd_i[c];
          rx_tmr  <= rx_tmr + 17'h00001;
          if (!receive_enable_bit)
            rx_state <= RX_IDLE;
          else
          begin
            unique case (rx_state)
              RX_IDLE:
              begin
                rx_tmr <= '0;
                if (rx_fall)
                  rx_state <= RX_START;
              end
              RX_START:
                if (rx_half)
                begin
                  rx_tmr   <= '0;
                  rx_cnt   <= 4'h0;
                  rx_sh    <= 9'h000;
                  rx_state <= rxd_i[c] ? RX_IDLE : RX_DATA;
                end
              RX_DATA:
                if (rx_tick)
                begin
                  rx_tmr <= '0;
                  rx_sh[rx_cnt] <= rxd_i[c];
                  rx_cnt <= rx_cnt + 4'h1;
                  if (rx_cnt == last_bit)
                    rx_state <= RX_STOP;
                end
              RX_STOP:
                if (rx_tick)
                  rx_state <= RX_IDLE;
            endcase
          end
        end
      end

      // interrupt request per channel
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          irq_o[c] <= 1'b0;
        else
          irq_o[c] <= channel_irq_enable & (tx_done_flag | rx_done_flag);
      end
    end
  endgenerate
endmodule // dual_async_serial_transceiver
`default_nettype wire

// ===== bench/dual_serial_sva.sv
`timescale 1ns/10ps
`default_nettype none
module dual_serial_sva
(
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic                          cyc_i,
  input wire logic                          stb_i,
  input wire logic                          we_i,
  input wire logic [serial_pkg::ADDR_W-1:0] adr_i,
  input wire logic [serial_pkg::DATA_W-1:0] dat_o,
  input wire logic                          ack_o,
  input wire logic [serial_pkg::NUM_CH-1:0] txd_o,
  input wire logic [serial_pkg::NUM_CH-1:0] irq_o
);
  import serial_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // request taken now; buffer writes may stall on a full queue
  wire logic taken  = cyc_i && stb_i && !ack_o;
  wire logic buf_wr = we_i && (adr_i[17:2] == BUF_IDX[0] || adr_i[17:2] == BUF_IDX[1]);
  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence
  a_ack_pulse: assert property (ack_o |-> s_ack_pulse)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_ack_prompt: assert property (taken && !buf_wr |=> ack_o)
    else $error("access not answered next cycle");
  a_upper_zero: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_unmapped_zero: assert property (ack_o && !we_i && adr_i[17:2] == 16'h0001 |-> dat_o == 32'h00000000)
    else $error("unmapped read not zero");
  a_data_hold: assert property (!taken |=> $stable(dat_o))
    else $error("read data changed without access");
  a_reset_lines: assert property ($fell(rst_i) |-> txd_o == 2'h3 && irq_o == 2'h0 && !ack_o)
    else $error("lines not idle after reset");
  a_reset_data: assert property ($fell(rst_i) |-> dat_o == 32'h00000000)
    else $error("read data not clear after reset");
endmodule // dual_serial_sva
bind dual_async_serial_transceiver dual_serial_sva dual_serial_sva_inst
  (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .txd_o, .irq_o);
`default_nettype wire

// ===== bench/serial_node.sv
`timescale 1ns/10ps
`default_nettype none
module serial_node
#(
  parameter int P   = 32,
  parameter int LEN = 11
)
(
  input  wire logic        clk_i,
  input  wire logic        txd_i,
  input  wire logic        go_i,
  input  wire logic [10:0] frame_i,
  output var  logic        rxd_o,
  output var  logic [10:0] got_o,
  output var  int          cnt_o
);
  logic [10:0] got;
  // line idles high, nothing captured yet
  initial
  begin
    rxd_o = 1'b1;
    got_o = 11'h000;
    cnt_o = 0;
  end
  // sends start, data lsb first, stop; each bit lasts P clocks
  always @(posedge clk_i)
  begin
    if (go_i)
    begin
      for (int i = 0; i < LEN; i++)
      begin
        rxd_o <= frame_i[i];
        repeat (P) @(posedge clk_i);
      end
    end
  end
  // samples each sent bit at its middle, from the start edge on
  always @(negedge txd_i)
  begin
    repeat (P / 2) @(posedge clk_i);
    for (int i = 0; i < LEN; i++)
    begin
      if (i > 0)
        repeat (P) @(posedge clk_i);
      got[i] = txd_i;
    end
    got_o = got;
    cnt_o = cnt_o + 1;
  end
endmodule // serial_node
`default_nettype wire

// ===== bench/test_dual_async_serial_transceiver.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_dual_async_serial_transceiver;
  import serial_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [17:0] adr_i = 18'h00000;
  logic [3:0]  sel_i = 4'hF;
  logic [3:0]  wsel  = 4'hF;
  logic [31:0] dat_i = 32'h00000000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [1:0]  txd_o, irq_o;
  logic [1:0]  go = 2'h0;
  wire  [1:0]  rxd;
  logic [10:0] frame [2];
  logic [10:0] got [2];
  int          cnt [2];
  int          n_fail = 0;
  int          n_tests = 0;
  int          n, base;
  logic [7:0]  q;
  logic [15:0] regs [10] = '{CTRL_IDX[0], BUF_IDX[0], FAST_IDX[0], RELL_IDX[0], RELH_IDX[0],
                             CTRL_IDX[1], BUF_IDX[1], FAST_IDX[1], RELL_IDX[1], RELH_IDX[1]};
  dual_async_serial_transceiver dual_async_serial_transceiver_inst (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .rxd_i(rxd), .txd_o, .irq_o);
  serial_node #(.P(32), .LEN(11)) node_a (.clk_i, .txd_i(txd_o[0]), .go_i(go[0]), .frame_i(frame[0]),
    .rxd_o(rxd[0]), .got_o(got[0]), .cnt_o(cnt[0]));
  serial_node #(.P(32), .LEN(10)) node_b (.clk_i, .txd_i(txd_o[1]), .go_i(go[1]), .frame_i(frame[1]),
    .rxd_o(rxd[1]), .got_o(got[1]), .cnt_o(cnt[1]));
  // 4 ns clock
  initial
  begin
    forever #2 clk_i = ~clk_i;
  end
  // one classic cycle, held until ack is seen, released after that edge
  task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= wsel;
    adr_i <= {idx, 2'h0};
    dat_i <= {24'h000000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, r);
  endtask
  task automatic rd(input logic [15:0] idx, output logic [7:0] r);
    bus(1'b0, idx, 8'h00, r);
  endtask
  // polls a control register until all given flag bits are set
  task automatic wait_flag(input int c, input logic [7:0] m);
    logic [7:0] r;
    r = 8'h00;
    while ((r & m) !== m)
      rd(CTRL_IDX[c], r);
  endtask
  task automatic send(input int c, input logic [10:0] f);
    frame[c] <= f;
    go[c] <= 1'b1;
    @(posedge clk_i);
    go[c] <= 1'b0;
  endtask
  // clocks of the start bit on channel zero
  task automatic low_len(output int len);
    do @(negedge clk_i); while (txd_o[0] !== 1'b0);
    len = 0;
    while (txd_o[0] === 1'b0)
    begin
      len++;
      @(negedge clk_i);
    end
  endtask
  task give_verdict;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (regs[i])
    begin
      rd(regs[i], q);
      `CHK(q, BYTE_RST)
    end
    wr(16'h0001, 8'h5A);
    rd(16'h0001, q);
    `CHK(q, 8'h00)
    for (int c = 0; c < 2; c++)
    begin
      wr(RELL_IDX[c], 8'hFF);
      wr(RELH_IDX[c], 8'h03);
      rd(RELH_IDX[c], q);
      `CHK(q, 8'h03)
    end
    // a write without byte lane zero is answered but stores nothing
    wsel = 4'hE;
    wr(RELL_IDX[1], 8'h00);
    wsel = 4'hF;
    rd(RELL_IDX[1], q);
    `CHK(q, 8'hFF)
    $display("test registers done");
    wr(CTRL_IDX[0], 8'h08);
    wr(BUF_IDX[0], 8'hFF);
    low_len(n);
    `CHK(n, 32)
    wait_flag(0, 8'h02);
    wr(CTRL_IDX[0], 8'h4A);
    wr(BUF_IDX[0], 8'hA5);
    wait_flag(0, 8'h02);
    `CHK(got[0], {1'h1, 1'h1, 8'hA5, 1'h0})
    @(negedge clk_i);
    `CHK(irq_o[0], 1'h1)
    wr(CTRL_IDX[0], 8'h48);
    rd(CTRL_IDX[0], q);
    `CHK(q, 8'h4A)
    wr(CTRL_IDX[0], 8'h02);
    rd(CTRL_IDX[0], q);
    `CHK(q, 8'h00)
    `CHK(irq_o[0], 1'h0)
    $display("test transmit done");
    wr(CTRL_IDX[0], 8'h10);
    send(0, {1'h1, 1'h1, 8'h3C, 1'h0});
    wait_flag(0, 8'h01);
    rd(BUF_IDX[0], q);
    `CHK(q, 8'h3C)
    rd(CTRL_IDX[0], q);
    `CHK(q, 8'h15)
    wr(CTRL_IDX[0], 8'h31);
    send(0, {1'h1, 1'h0, 8'h11, 1'h0});
    repeat (400) @(posedge clk_i);
    rd(CTRL_IDX[0], q);
    `CHK(q, 8'h30)
    rd(BUF_IDX[0], q);
    `CHK(q, 8'h3C)
    send(0, {1'h1, 1'h1, 8'h77, 1'h0});
    wait_flag(0, 8'h01);
    rd(BUF_IDX[0], q);
    `CHK(q, 8'h77)
    wr(CTRL_IDX[0], 8'h01);
    send(0, {1'h1, 1'h1, 8'h22, 1'h0});
    repeat (400) @(posedge clk_i);
    rd(CTRL_IDX[0], q);
    `CHK(q, 8'h00)
    $display("test receive done");
    wr(CTRL_IDX[1], 8'h90);
    send(1, {1'h1, 1'h1, 8'h5A, 1'h0});
    wait_flag(1, 8'h01);
    rd(BUF_IDX[1], q);
    `CHK(q, 8'h5A)
    rd(CTRL_IDX[1], q);
    `CHK(q, 8'h95)
    wr(BUF_IDX[1], 8'hC3);
    wait_flag(1, 8'h02);
    `CHK(got[1][9:0], {1'h1, 8'hC3, 1'h0})
    `CHK(irq_o[1], 1'h0)
    $display("test eight bit done");
    wr(CTRL_IDX[0], 8'h08);
    base = cnt[0];
    for (int i = 1; i < 5; i++)
      wr(BUF_IDX[0], 8'(i * 17));
    repeat (1500) @(posedge clk_i);
    `CHK(cnt[0] - base, 4)
    `CHK(got[0], {1'h1, 1'h1, 8'h44, 1'h0})
    wr(FAST_IDX[0], 8'h81);
    rd(FAST_IDX[0], q);
    `CHK(q, 8'h81)
    wr(BUF_IDX[0], 8'hFF);
    low_len(n);
    `CHK(n, 2)
    $display("test queue and fast baud done");
    give_verdict();
  end
  // cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end
endmodule // test_dual_async_serial_transceiver
`default_nettype wire
